/* File: rtl/pswc_defs.svh */
// register offsets, field positions, reset values and sizes of the waveform controller
`ifndef PSWC_DEFS_SVH
`define PSWC_DEFS_SVH
`define PSWC_OFF_CTRL 6'h00
`define PSWC_OFF_SA 6'h04
`define PSWC_OFF_RA 6'h08
`define PSWC_OFF_SB 6'h0c
`define PSWC_OFF_RB 6'h10
`define PSWC_OFF_CAPT 6'h14
`define PSWC_OFF_STAT 6'h18
`define PSWC_OFF_MASK 6'h1c
`define PSWC_OFF_CNT 6'h20
`define PSWC_CTRL_W 18
`define PSWC_CTRL_RST 18'h00000
`define PSWC_CMP_W 12
`define PSWC_FRAC_LSB 12
`define PSWC_FRAC_MSB 15
`define PSWC_RB_W 16
`define PSWC_CMP_RST 12'h000
`define PSWC_FRAC_RST 4'h0
`define PSWC_ST_OVF 0
`define PSWC_ST_FLT 1
`define PSWC_ST_CAP 2
`define PSWC_ST_HOLD 3
`define PSWC_ST_RUN 4
`define PSWC_IRQ_W 3
`define PSWC_MASK_RST 3'h0
`endif

/* File: rtl/pswc_pkg.sv */
// types shared by the waveform controller
package pswc_pkg;
   // software control word, top bit first, run is bit 0
   typedef struct packed {
      logic [3:0] matrix;   // {b_hi, b_lo, a_hi, a_lo} levels per sub-cycle
      logic dup3_sel;
      logic dup2_sel;
      logic mat_en;
      logic [1:0] in_en;
      logic [1:0] in_fault;
      logic pol1;
      logic pol0;
      logic sync_en;
      logic clk_sel;
      logic [1:0] mode;
      logic run;
   } pswc_ctrl_t;
   typedef enum logic [1:0] {
      MODE_FOUR = 2'h0, MODE_TWO = 2'h1, MODE_ONE = 2'h2, MODE_CTR = 2'h3
   } pswc_mode_t;
   typedef enum logic [1:0] {
      PH_A0 = 2'h0, PH_A1 = 2'h1, PH_B0 = 2'h2, PH_B1 = 2'h3
   } pswc_phase_t;
   typedef struct packed {
      logic read;
      logic write;
      logic [5:0] address;
      logic [31:0] writedata;
   } pswc_avs_req_t;
   typedef struct packed {
      logic dup3;
      logic dup2;
      logic out1;
      logic out0;
   } pswc_outs_t;
endpackage : pswc_pkg

/* File: rtl/pswc_top.sv */
// power stage waveform controller with avalon-mm register slave
//
// The Avalon-MM slave port and the address map were decided locally.
`timescale 1ns/1ps
`include "pswc_defs.svh"
// Operation
// - one up/down counter between register limits
// - half a drives output 0, b output 1
// - two extra outputs copy output 0 or 1
// - output matrix sets levels per sub-cycle
// - per-output polarity, active low inverts level
// - half a set and clear 12-bit compares
// - half b set and clear 12-bit compares
// - half b clear word top nibble is fraction
// - retrigger copies counter into capture register
// - one irq from overflow, fault, capture
// - pin and comparator inputs, retrigger or fault
// - chain sync input and sync output
// - chain halt input and halt output
// - converter sync pulse from waveform timing
// - clocked from i/o clock or pll enable
// - cycle is sub-cycle a then b
// - new values load at last ramp top
// - centered mode counts up then down
// - four times plus mode shape outputs
// - fault input forces all outputs low
// - four-ramp, two-ramp, one-ramp or centered mode
module pswc_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire pswc_pkg::pswc_avs_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic pll_clk_en,
   input wire logic retrigger_fault_pin,
   input wire logic comparator_in,
   input wire logic chain_sync_in,
   input wire logic chain_halt_in,
   output logic chain_sync_out,
   output logic chain_halt_out,
   output logic converter_sync_pulse,
   output logic controller_irq,
   output logic [11:0] retrigger_capture_value,
   output pswc_pkg::pswc_outs_t pins
);
   import pswc_pkg::*;

   localparam int CW = `PSWC_CMP_W;

   // reverse bit order so extra-count cycles spread evenly over the frame
   function automatic logic [3:0] bitrev4(input logic [3:0] v);
      bitrev4 = {v[0], v[1], v[2], v[3]};
   endfunction : bitrev4

   function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
      hit = (a[5:2] == off[5:2]);
   endfunction : hit

   pswc_ctrl_t ctrl;
   logic [CW-1:0] sh_sa, sh_ra, sh_sb, sh_rb;
   logic [3:0] sh_frac;
   logic [CW-1:0] act_sa, act_ra, act_sb, act_rb;
   logic [3:0] act_frac;
   logic [`PSWC_IRQ_W-1:0] status, mask;
   logic [CW-1:0] cnt;
   pswc_phase_t ph;
   logic [3:0] frame;
   logic running, fault_hold, rd_done;
   logic [1:0] in_prev;
   logic [1:0] in_lvl;
   logic tick, run_eff, fault_now, retrig, restart;
   logic [CW-1:0] top;
   logic [CW:0] top_eff;
   logic last, at_top, cycle_end, upd, a_on, b_on, ctr_mode;
   logic wr;
   logic [2:0] ev_set, ev_clr;

   // bus: writes take effect at once, reads wait one cycle for registered data
   assign wr = avs_req.write;
   assign avs_waitrequest = avs_req.read & ~rd_done;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_done <= 1'b0;
         avs_readdata <= 32'h0;
      end else begin
         rd_done <= avs_req.read & ~rd_done;
         if (avs_req.read && !rd_done) begin
            avs_readdata <= 32'h0;   // unmapped and reserved bits read zero
            if (hit(avs_req.address, `PSWC_OFF_CTRL))
               avs_readdata[`PSWC_CTRL_W-1:0] <= ctrl;
            if (hit(avs_req.address, `PSWC_OFF_SA))
               avs_readdata[CW-1:0] <= sh_sa;
            if (hit(avs_req.address, `PSWC_OFF_RA))
               avs_readdata[CW-1:0] <= sh_ra;
            if (hit(avs_req.address, `PSWC_OFF_SB))
               avs_readdata[CW-1:0] <= sh_sb;
            if (hit(avs_req.address, `PSWC_OFF_RB))
               avs_readdata[`PSWC_RB_W-1:0] <= {sh_frac, sh_rb};
            if (hit(avs_req.address, `PSWC_OFF_CAPT))
               avs_readdata[CW-1:0] <= retrigger_capture_value;
            if (hit(avs_req.address, `PSWC_OFF_STAT))
               avs_readdata[`PSWC_ST_RUN:0] <= {running, fault_hold, status};
            if (hit(avs_req.address, `PSWC_OFF_MASK))
               avs_readdata[`PSWC_IRQ_W-1:0] <= mask;
            if (hit(avs_req.address, `PSWC_OFF_CNT))
               avs_readdata[CW-1:0] <= cnt;
         end
      end
   end

   // control and mask registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `PSWC_CTRL_RST;
         mask <= `PSWC_MASK_RST;
      end else if (wr) begin
         if (hit(avs_req.address, `PSWC_OFF_CTRL))
            ctrl <= avs_req.writedata[`PSWC_CTRL_W-1:0];
         if (hit(avs_req.address, `PSWC_OFF_MASK))
            mask <= avs_req.writedata[`PSWC_IRQ_W-1:0];
      end
   end

   // shadow compares: software writes never touch the running waveform
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_sa <= `PSWC_CMP_RST;
         sh_ra <= `PSWC_CMP_RST;
         sh_sb <= `PSWC_CMP_RST;
         sh_rb <= `PSWC_CMP_RST;
         sh_frac <= `PSWC_FRAC_RST;
      end else if (wr) begin
         if (hit(avs_req.address, `PSWC_OFF_SA))
            sh_sa <= avs_req.writedata[CW-1:0];
         if (hit(avs_req.address, `PSWC_OFF_RA))
            sh_ra <= avs_req.writedata[CW-1:0];
         if (hit(avs_req.address, `PSWC_OFF_SB))
            sh_sb <= avs_req.writedata[CW-1:0];
         if (hit(avs_req.address, `PSWC_OFF_RB)) begin
            sh_rb <= avs_req.writedata[CW-1:0];
            sh_frac <= avs_req.writedata[`PSWC_FRAC_MSB:`PSWC_FRAC_LSB];
         end
      end
   end

   // active set loads as a whole at the update point, or freely while stopped
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_sa <= `PSWC_CMP_RST;
         act_ra <= `PSWC_CMP_RST;
         act_sb <= `PSWC_CMP_RST;
         act_rb <= `PSWC_CMP_RST;
         act_frac <= `PSWC_FRAC_RST;
      end else if (upd || !running) begin
         act_sa <= sh_sa;
         act_ra <= sh_ra;
         act_sb <= sh_sb;
         act_rb <= sh_rb;
         act_frac <= sh_frac;
      end
   end

   // clock source: every cycle for the i/o clock, the pll enable otherwise
   assign tick = ctrl.clk_sel ? pll_clk_en : 1'b1;
   // a halt from the chain stops this controller only when chained
   assign run_eff = ctrl.run & ~(ctrl.sync_en & chain_halt_in);

   // input conditioning for pin and comparator
   assign in_lvl = {comparator_in, retrigger_fault_pin} & ctrl.in_en;
   assign fault_now = |(in_lvl & ctrl.in_fault);
   assign retrig = |(in_lvl & ~in_prev & ~ctrl.in_fault);
   assign restart = retrig | (ctrl.sync_en & chain_sync_in);

   // ramp limits per running mode
   assign ctr_mode = (ctrl.mode == MODE_CTR);
   always_comb begin
      top = act_rb;
      last = 1'b1;
      case (pswc_mode_t'(ctrl.mode))
         MODE_FOUR: begin   // each time owns a ramp
            case (ph)
               PH_A0: top = act_sa;
               PH_A1: top = act_ra;
               PH_B0: top = act_sb;
               default: top = act_rb;
            endcase
            last = (ph == PH_B1);
         end
         MODE_TWO: begin
            top = (ph == PH_A0) ? act_ra : act_rb;
            last = (ph == PH_B0);
         end
         MODE_ONE: last = 1'b1;
         MODE_CTR: last = (ph == PH_A0);   // up ramp is the only top
         default: last = 1'b1;
      endcase
   end

   // the last ramp is one count longer on the frame cycles the fraction picks
   assign top_eff = {1'b0, top} + {{CW{1'b0}}, (last && (bitrev4(frame) < act_frac))};
   assign at_top = ({1'b0, cnt} >= top_eff);   // a limit below the count ends the ramp instead of wrapping
   assign upd = tick & running & at_top & last;
   assign cycle_end = tick & running & (ctr_mode ? (ph == PH_B0 && cnt == '0) : (at_top && last));

   // counter and sequence position
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
         ph <= PH_A0;
      end else if (!running || restart) begin
         cnt <= '0;
         ph <= PH_A0;
      end else if (tick) begin
         if (ctr_mode) begin   // up to top then back down to zero
            if (ph == PH_A0) begin
               ph <= at_top ? PH_B0 : PH_A0;
               cnt <= at_top ? cnt - 1'b1 : cnt + 1'b1;
            end else if (cnt == '0) begin
               ph <= PH_A0;
               cnt <= cnt + 1'b1;
            end else begin
               cnt <= cnt - 1'b1;
            end
         end else if (at_top) begin
            cnt <= '0;
            case (pswc_mode_t'(ctrl.mode))
               MODE_FOUR: ph <= pswc_phase_t'(ph + 2'h1);
               MODE_TWO: ph <= (ph == PH_A0) ? PH_B0 : PH_A0;
               default: ph <= PH_A0;
            endcase
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
   end

   // run state, frame position and retrigger edge memory
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         running <= 1'b0;
         frame <= 4'h0;
         in_prev <= 2'h0;
      end else begin
         running <= run_eff;
         in_prev <= in_lvl;
         if (!running)
            frame <= 4'h0;
         else if (cycle_end)
            frame <= frame + 4'h1;
      end
   end

   // fault hold lasts until a cycle start with the inputs quiet
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         fault_hold <= 1'b0;
      else if (fault_now)
         fault_hold <= 1'b1;
      else if (cycle_end || restart || !running)
         fault_hold <= 1'b0;
   end

   // active windows from the four times and the mode
   always_comb begin
      a_on = 1'b0;
      b_on = 1'b0;
      case (pswc_mode_t'(ctrl.mode))
         MODE_FOUR: begin
            a_on = (ph == PH_A1);
            b_on = (ph == PH_B1);
         end
         MODE_TWO: begin
            a_on = (ph == PH_A0) && (cnt > act_sa);
            b_on = (ph == PH_B0) && (cnt > act_sb);
         end
         MODE_ONE: begin   // outputs may overlap here
            a_on = (cnt > act_sa) && (cnt <= act_ra);
            b_on = (cnt > act_sb) && (cnt <= act_rb);
         end
         default: begin
            a_on = (cnt < act_sa);
            b_on = (cnt >= act_sb);
         end
      endcase
      if (ctrl.mat_en) begin   // sub-cycle picks a row of the matrix
         a_on = (ph == PH_A0 || ph == PH_A1) ? ctrl.matrix[0] : ctrl.matrix[2];
         b_on = (ph == PH_A0 || ph == PH_A1) ? ctrl.matrix[1] : ctrl.matrix[3];
      end
      if (!running) begin
         a_on = 1'b0;
         b_on = 1'b0;
      end
   end

   // output pins; a fault overrides polarity so the pins really go low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pins <= '0;
      end else if (fault_now || fault_hold) begin
         pins <= '0;
      end else begin
         pins.out0 <= a_on ^ ctrl.pol0;
         pins.out1 <= b_on ^ ctrl.pol1;
         pins.dup2 <= ctrl.dup2_sel ? (b_on ^ ctrl.pol1) : (a_on ^ ctrl.pol0);
         pins.dup3 <= ctrl.dup3_sel ? (b_on ^ ctrl.pol1) : (a_on ^ ctrl.pol0);
      end
   end

   // capture register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         retrigger_capture_value <= `PSWC_CMP_RST;
      else if (retrig)
         retrigger_capture_value <= cnt;
   end

   // sticky events, write one to clear; a new event wins over the clear
   assign ev_set = {retrig, fault_now & ~fault_hold, cycle_end};
   assign ev_clr = (wr && hit(avs_req.address, `PSWC_OFF_STAT)) ? avs_req.writedata[`PSWC_IRQ_W-1:0] : 3'h0;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         status <= `PSWC_MASK_RST;
      else
         status <= (status & ~ev_clr) | ev_set;
   end
   assign controller_irq = |(status & mask);

   // chain sync and converter strobes, one cycle each; halt output is a level
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chain_sync_out <= 1'b0;
         chain_halt_out <= 1'b1;
         converter_sync_pulse <= 1'b0;
      end else begin
         chain_sync_out <= cycle_end;
         chain_halt_out <= ~run_eff;
         converter_sync_pulse <= tick & running & (cnt == act_ra);
      end
   end

   // checks on the design's own behaviour
   sequence s_four_a_end;
      tick && running && !restart && at_top && ctrl.mode == MODE_FOUR && ph == PH_A1;
   endsequence
   sequence s_enter_b;
      ph == PH_B0 && cnt == '0;
   endsequence

   property p_sub_cycle_order;
      @(posedge clk) disable iff (!rst_n) s_four_a_end |=> s_enter_b;
   endproperty
   a_sub_cycle_order: assert property (p_sub_cycle_order) else $error("sub-cycle b did not follow a");

   property p_capture;
      @(posedge clk) disable iff (!rst_n) retrig |=> retrigger_capture_value == $past(cnt);
   endproperty
   a_capture: assert property (p_capture) else $error("capture missed counter value");

   property p_shadow_hold;
      @(posedge clk) disable iff (!rst_n) (running && !upd) |=> act_sa == $past(act_sa) && act_rb == $past(act_rb);
   endproperty
   a_shadow_hold: assert property (p_shadow_hold) else $error("active set changed mid cycle");

   property p_update;
      @(posedge clk) disable iff (!rst_n) upd |=> act_ra == $past(sh_ra) && act_frac == $past(sh_frac);
   endproperty
   a_update: assert property (p_update) else $error("update did not load shadow set");

   property p_fault_low;
      @(posedge clk) disable iff (!rst_n) fault_now |=> pins == '0 ##1 (fault_hold || pins == '0);
   endproperty
   a_fault_low: assert property (p_fault_low) else $error("fault did not force pins low");

   property p_irq_fault;
      @(posedge clk) disable iff (!rst_n) (fault_now && !fault_hold && mask[`PSWC_ST_FLT]) |=> controller_irq;
   endproperty
   a_irq_fault: assert property (p_irq_fault) else $error("fault did not raise irq");

   property p_count_range;
      @(posedge clk) disable iff (!rst_n) (running && !ctr_mode) |-> {1'b0, cnt} <= top_eff || $changed(ctrl.mode);
   endproperty
   a_count_range: assert property (p_count_range) else $error("counter passed its limit");

   property p_sync_out;
      @(posedge clk) disable iff (!rst_n) cycle_end |=> chain_sync_out ##1 (chain_sync_out == $past(cycle_end));
   endproperty
   a_sync_out: assert property (p_sync_out) else $error("sync output not a cycle-end pulse");

   property p_halt;
      @(posedge clk) disable iff (!rst_n) (ctrl.sync_en && chain_halt_in) |=> !running && chain_halt_out;
   endproperty
   a_halt: assert property (p_halt) else $error("chain halt ignored");

endmodule : pswc_top

/* File: tb/pswc_bridge.sv */
// half bridge driver model standing behind the controller outputs
`timescale 1ns/1ps
module pswc_bridge (
   input wire logic clk,
   input wire logic rst_n,
   input wire pswc_pkg::pswc_outs_t pins,
   input wire logic trip,
   input wire logic zc,
   output logic sense,
   output logic zc_pin,
   output logic [7:0] on_cnt
);
   import pswc_pkg::*;
   // over-current comparator and zero-crossing pin, registered like real sense paths
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sense <= 1'b0;
         zc_pin <= 1'b0;
      end else begin
         sense <= trip;
         zc_pin <= zc;
      end
   end
   // high side conduction time, only useful to see the load is really switched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         on_cnt <= 8'h00;
      end else if (pins.out0) begin
         on_cnt <= on_cnt + 8'h01;
      end
   end
endmodule : pswc_bridge

/* File: tb/tb.sv */
// self-checking bench of the power stage waveform controller
`timescale 1ns/1ps
`include "pswc_defs.svh"
module tb;
   import pswc_pkg::*;
   logic clk, rst_n, pll_clk_en, sync_in, halt_in, sync_out, halt_out, conv, irq, sense, zc_pin, trip, zc;
   pswc_avs_req_t avs_req;
   logic [31:0] rdata;
   logic pll_half;
   logic wait_req;
   logic [11:0] capt;
   pswc_outs_t pins;
   int error_cnt, n_checks;
   pswc_ctrl_t c;
   logic [31:0] q;
   int k;
   pswc_top i_pswc_top (.clk(clk), .rst_n(rst_n), .avs_req(avs_req), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .pll_clk_en(pll_clk_en), .retrigger_fault_pin(zc_pin),
      .comparator_in(sense), .chain_sync_in(sync_in), .chain_halt_in(halt_in), .chain_sync_out(sync_out),
      .chain_halt_out(halt_out), .converter_sync_pulse(conv), .controller_irq(irq),
      .retrigger_capture_value(capt), .pins(pins));
   pswc_bridge i_pswc_bridge (.clk(clk), .rst_n(rst_n), .pins(pins), .trip(trip), .zc(zc),
      .sense(sense), .zc_pin(zc_pin), .on_cnt());
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // pll rate as a one-cycle enable every second clock while pll_half is set
   always_ff @(posedge clk) begin
      pll_clk_en <= pll_half & ~pll_clk_en;
   end
   task summarize;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // one avalon transfer; request held until waitrequest is seen low at an edge
   task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      avs_req <= '{read: ~w, write: w, address: a, writedata: d};
      do @(posedge clk); while (wait_req !== 1'b0);
      q = rdata;
      avs_req <= '0;
      @(posedge clk);
   endtask : bus
   task ctrl_wr;
      bus(1'b1, `PSWC_OFF_CTRL, {14'h0, c});
   endtask : ctrl_wr
   // counts high cycles of one output: 0 out0, 1 chain sync, 2 converter sync, 3 out1
   task cnt(input int sel, input int n);
      k = 0;
      repeat (n) begin
         @(posedge clk);
         case (sel)
            0: k += (pins.out0 === 1'b1);
            1: k += (sync_out === 1'b1);
            2: k += (conv === 1'b1);
            default: k += (pins.out1 === 1'b1);
         endcase
      end
   endtask : cnt
   task t_reset;
      chk("pins", {28'h0, pins}, 32'h0);
      chk("halt_out", {31'h0, halt_out}, 32'h1);
      bus(1'b0, `PSWC_OFF_CTRL, 32'h0);
      chk("ctrl", q, 32'h0);
      bus(1'b0, 6'h3c, 32'h0);
      chk("unmapped", q, 32'h0);
      bus(1'b1, 6'h3c, 32'hffffffff);
      bus(1'b0, 6'h3c, 32'h0);
      chk("unmapped", q, 32'h0);
   endtask : t_reset
   task t_shadow;
      bus(1'b1, `PSWC_OFF_RB, 32'h0000a004);
      bus(1'b0, `PSWC_OFF_RB, 32'h0);
      chk("clear b", q, 32'h0000a004);
      bus(1'b1, `PSWC_OFF_SA, 32'h00000001);
      bus(1'b1, `PSWC_OFF_RA, 32'h00000003);
      bus(1'b0, `PSWC_OFF_SA, 32'h0);
      chk("set a", q, 32'h1);
      bus(1'b1, `PSWC_OFF_SB, 32'h00000003);
      bus(1'b1, `PSWC_OFF_RB, 32'h00000004);
   endtask : t_shadow
   // one ramp, period of five counts, out0 high on counts two and three
   task t_walk;
      c = '0;
      c.mode = MODE_ONE;
      c.run = 1'b1;
      ctrl_wr();
      repeat (10) @(posedge clk);
      cnt(0, 20);
      chk("out0 high", k, 8);
      cnt(3, 20);
      chk("out1 high", k, 4);
      cnt(1, 20);
      chk("sync out", k, 4);
      cnt(2, 20);
      chk("conv sync", k, 4);
      bus(1'b0, `PSWC_OFF_STAT, 32'h0);
      chk("running", {31'h0, q[`PSWC_ST_RUN]}, 32'h1);
   endtask : t_walk
   task t_polarity_dup;
      c.pol0 = 1'b1;
      c.dup3_sel = 1'b1;
      ctrl_wr();
      repeat (10) @(posedge clk);
      cnt(0, 20);
      chk("out0 inverted", k, 12);
      repeat (20) begin
         @(posedge clk);
         chk("dup2", {31'h0, pins.dup2}, {31'h0, pins.out0});
         chk("dup3", {31'h0, pins.dup3}, {31'h0, pins.out1});
      end
      c.pol0 = 1'b0;
      ctrl_wr();
   endtask : t_polarity_dup
   // matrix rows: out0 high in sub-cycle b only, out1 in sub-cycle a only
   task t_matrix;
      c.mode = MODE_TWO;
      c.mat_en = 1'b1;
      c.matrix = 4'h6;
      ctrl_wr();
      repeat (20) @(posedge clk);
      cnt(0, 18);
      chk("matrix out0", k, 10);
      cnt(3, 18);
      chk("matrix out1", k, 8);
      c.mode = MODE_ONE;
      c.mat_en = 1'b0;
      ctrl_wr();
   endtask : t_matrix
   task t_update;
      bus(1'b1, `PSWC_OFF_RA, 32'h00000002);
      bus(1'b0, `PSWC_OFF_RA, 32'h0);
      chk("shadow a", q, 32'h2);
      repeat (10) @(posedge clk);
      cnt(0, 20);
      chk("out0 after update", k, 4);
      bus(1'b1, `PSWC_OFF_RA, 32'h00000003);
   endtask : t_update
   // fraction 8 stretches every second cycle by one count: 10 cycle ends in 55 clocks
   task t_fraction;
      bus(1'b1, `PSWC_OFF_MASK, 32'h1);
      chk("irq overflow", {31'h0, irq}, 32'h1);
      bus(1'b1, `PSWC_OFF_RB, 32'h00008004);
      repeat (12) @(posedge clk);
      cnt(1, 55);
      chk("sync out with fraction", k, 10);
      bus(1'b1, `PSWC_OFF_RB, 32'h00000004);
   endtask : t_fraction
   task t_fault;
      c.in_fault = 2'b10;
      c.in_en = 2'b10;
      ctrl_wr();
      bus(1'b1, `PSWC_OFF_MASK, 32'h2);
      trip <= 1'b1; // over-current on the comparator input
      repeat (4) @(posedge clk);
      repeat (10) begin
         @(posedge clk);
         chk("pins in fault", {28'h0, pins}, 32'h0);
      end
      chk("irq", {31'h0, irq}, 32'h1);
      bus(1'b0, `PSWC_OFF_STAT, 32'h0);
      chk("fault flag", q & 32'h2, 32'h2);
      trip <= 1'b0;
      bus(1'b1, `PSWC_OFF_STAT, 32'h7);
      repeat (20) @(posedge clk);
      cnt(0, 20);
      chk("out0 resumed", k, 8);
      chk("irq cleared", {31'h0, irq}, 32'h0);
   endtask : t_fault
   task t_capture;
      c.in_fault = 2'b00;
      c.in_en = 2'b01;
      ctrl_wr();
      bus(1'b1, `PSWC_OFF_MASK, 32'h4);
      zc <= 1'b1;
      repeat (5) @(posedge clk);
      zc <= 1'b0;
      chk("irq capture", {31'h0, irq}, 32'h1);
      bus(1'b0, `PSWC_OFF_CAPT, 32'h0);
      chk("capture range", {31'h0, q[11:0] < 12'h005}, 32'h1);
      chk("capture port", {20'h0, capt}, q);
      bus(1'b1, `PSWC_OFF_STAT, 32'h7);
      c.in_en = 2'b00;
      ctrl_wr();
   endtask : t_capture
   task t_chain;
      c.sync_en = 1'b1;
      ctrl_wr();
      sync_in <= 1'b1;
      repeat (4) @(posedge clk);
      cnt(0, 20);
      chk("out0 held by restart", k, 0);
      sync_in <= 1'b0;
      halt_in <= 1'b1;
      repeat (4) @(posedge clk);
      chk("halt out", {31'h0, halt_out}, 32'h1);
      bus(1'b0, `PSWC_OFF_STAT, 32'h0);
      chk("stopped", {31'h0, q[`PSWC_ST_RUN]}, 32'h0);
      halt_in <= 1'b0;
      repeat (4) @(posedge clk);
      chk("halt out low", {31'h0, halt_out}, 32'h0);
      c.sync_en = 1'b0;
      ctrl_wr();
   endtask : t_chain
   task t_pll;
      c.clk_sel = 1'b1;
      ctrl_wr();
      cnt(1, 20);
      chk("frozen", k, 0);
      pll_half <= 1'b1;
      repeat (10) @(posedge clk);
      cnt(1, 20);
      chk("pll steps", k, 2);
      c.clk_sel = 1'b0;
      ctrl_wr();
      pll_half <= 1'b0;
   endtask : t_pll
   task t_modes;
      for (int m = 0; m < 4; m++) begin
         c.mode = m[1:0];
         ctrl_wr();
         repeat (30) @(posedge clk);
         cnt(1, 60);
         chk("cycle ends", {31'h0, k > 0 && k < 13}, 32'h1);
      end
   endtask : t_modes
   initial begin
      rst_n = 1'b0;
      avs_req = '0;
      pll_half = 1'b0;
      sync_in = 1'b0;
      halt_in = 1'b0;
      trip = 1'b0;
      zc = 1'b0;
      error_cnt = 0;
      n_checks = 0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_shadow();
      t_walk();
      t_polarity_dup();
      t_matrix();
      t_update();
      t_fraction();
      t_fault();
      t_capture();
      t_chain();
      t_pll();
      t_modes();
      summarize();
   end
   // watchdog well beyond the thousand or so cycles the scenarios need
   initial begin
      #(25 * 20000);
      error_cnt++;
      summarize();
   end
endmodule : tb
